// ---- rtl/dst_pkg.sv ----
// Package with constants and carrier types for the dword sync tracker.
package dst_pkg;
    // ------------------------------------------------------------
    // Character and timing constants
    // ------------------------------------------------------------
    localparam logic [7:0] DST_K28_5 = 8'hBC;
    localparam logic [7:0] DST_K28_3 = 8'h7C;
    localparam int DST_CLK_HZ = 20000000;
    localparam int DST_RESYNC_US = 1000;
    localparam int DST_RESYNC_CYCLES = DST_CLK_HZ / 1000000 * DST_RESYNC_US;
    localparam int DST_TMR_W = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        DST_HUNT       = 4'h0,
        DST_ONE_GOOD   = 4'h1,
        DST_TWO_GOOD   = 4'h2,
        DST_LOCKED     = 4'h3,
        DST_ERR1       = 4'h4,
        DST_ERR1_RCV   = 4'h5,
        DST_ERR2       = 4'h6,
        DST_ERR2_RCV   = 4'h7,
        DST_ERR3       = 4'h8,
        DST_ERR3_RCV   = 4'h9
    } dst_state_e;

    // One received dword: characters first..last and control flags.
    typedef struct packed {
        logic [7:0] ch0;
        logic [7:0] ch1;
        logic [7:0] ch2;
        logic [7:0] ch3;
        logic [3:0] is_k;
        logic code_err;
    } dst_dword_s;

    typedef struct packed {
        dst_state_e state;
        logic [DST_TMR_W-1:0] timer;
        logic timer_run;
        logic timeout;
        logic hunting;
        logic find_dword;
        logic sync_dropped_msg;
        logic fwd_valid;
        logic [31:0] fwd_data;
        logic [3:0] fwd_k;
        logic locked;
    } dst_regs_s;
endpackage

// ---- rtl/dst_dword_sync_fsm.sv ----
// Receive dword synchronization state machine with dword classifier.
//
// Summary of operation
// - One-good state: primitive advances; invalid or timeout returns to hunt.
// - Two-good state: primitive locks; invalid or timeout returns to hunt.
// - On lock forward the locking primitive and every later dword but the one dropping sync.
// - Locked ignores valid dwords; first invalid goes to one-error.
// - One-error: valid goes recovering, invalid goes two-error.
// - One-error-recovering: valid relocks, invalid goes two-error.
// - Two-error: valid goes recovering, invalid goes three-error.
// - Two-error-recovering: valid back to one-error, invalid to three-error.
// - Three-error: valid recovers; invalid sends sync dropped, back to hunt.
// - Three-error-recovering: valid to two-error; invalid drops sync.
// - Target holds spin-up after out-of-band detect until power grants it.
// - Expander may hold spin-up; reported and released by management.
// - Primitive only when first character is one of two control codes.
// - Native primitives lead K28.5, SATA ones K28.3, then data characters.
// - Characters handled in transmission order, no byte reordering.
// - Resync timeout starts at 1 ms when hunting begins on start.
// - Every aligned dword is classified invalid, primitive or data.
// - Hunt moves to one-good after a hunt request and a primitive.
// - Dwords are not forwarded while synchronization is not held.
`timescale 1ns/100ps
module dst_dword_sync_fsm
    import dst_pkg::*;
#(
    parameter int RESYNC_CYCLES = DST_RESYNC_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Control from phy reset sequencer and management
    input wire logic START_REQ,
    input wire logic STOP_REQ,
    input wire logic DISABLE_REQ,
    input wire logic MGMT_RESET,
    input wire logic SYNC_RESET,
    // Spin-up hold controls
    input wire logic OOB_SAS_SEEN,
    input wire logic SPINUP_GRANT,
    input wire logic HOLD_ENABLE,
    input wire logic HOLD_RELEASE,
    // Aligned dword stream from the receiver
    input wire logic DWORD_VALID,
    input wire dst_dword_s DWORD_IN,
    // Messages to phy reset sequencer and aligner
    output logic FIND_DWORD,
    output logic SYNC_DROPPED,
    output logic RESYNC_TIMEOUT,
    output logic SYNC_LOCKED,
    // Forwarded stream to link layer
    output logic FWD_VALID,
    output logic [31:0] FWD_DATA,
    output logic [3:0] FWD_K,
    // Spin-up hold
    output logic SPINUP_ALLOW,
    output logic SPINUP_HELD
);
    localparam logic [DST_TMR_W-1:0] TMR_LOAD =
        DST_TMR_W'(RESYNC_CYCLES - 1);

    dst_regs_s r;
    dst_regs_s next_r;
    logic spin_allow;
    logic next_spin_allow;
    logic spin_held;
    logic next_spin_held;
    logic sas_seen;
    logic next_sas_seen;

    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    logic lead_ok;
    logic tail_data;
    logic is_prim;
    logic is_invalid;
    logic is_good;

    always_comb begin
        lead_ok = DWORD_IN.is_k[3] &&
            (DWORD_IN.ch0 == DST_K28_5 || DWORD_IN.ch0 == DST_K28_3);
        tail_data = (DWORD_IN.is_k[2:0] == 3'h0);
        is_invalid = DWORD_VALID &&
            (DWORD_IN.code_err || (DWORD_IN.is_k[3] && !lead_ok) ||
             (DWORD_IN.is_k[2:0] != 3'h0));
        is_prim = DWORD_VALID && !is_invalid && lead_ok && tail_data;
        is_good = DWORD_VALID && !is_invalid;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.sync_dropped_msg = 1'b0;
        next_r.find_dword = 1'b0;
        next_r.fwd_valid = 1'b0;
        next_spin_allow = spin_allow;
        next_spin_held = spin_held;
        next_sas_seen = sas_seen;

        // Timer keeps running through the climb; timeout is sticky.
        if (r.timer_run) begin
            if (r.timer == '0) begin
                next_r.timeout = 1'b1;
                next_r.timer_run = 1'b0;
            end else begin
                next_r.timer = r.timer - 1'b1;
            end
        end

        case (r.state)
            DST_HUNT: begin
                if (START_REQ) begin
                    next_r.hunting = 1'b1;
                    next_r.find_dword = 1'b1;
                    next_r.timer = TMR_LOAD;
                    next_r.timer_run = 1'b1;
                    next_r.timeout = 1'b0;
                end else if (r.hunting && is_prim) begin
                    next_r.state = DST_ONE_GOOD;
                end
            end
            DST_ONE_GOOD: begin
                if (is_invalid || r.timeout) begin
                    next_r.state = DST_HUNT;
                    next_r.find_dword = 1'b1;
                end else if (is_prim) begin
                    next_r.state = DST_TWO_GOOD;
                end
            end
            DST_TWO_GOOD: begin
                if (is_invalid || r.timeout) begin
                    next_r.state = DST_HUNT;
                    next_r.find_dword = 1'b1;
                end else if (is_prim) begin
                    next_r.state = DST_LOCKED;
                    next_r.timer_run = 1'b0;
                end
            end
            DST_LOCKED: begin
                if (is_invalid) begin
                    next_r.state = DST_ERR1;
                end
            end
            DST_ERR1: begin
                if (is_invalid) begin
                    next_r.state = DST_ERR2;
                end else if (is_good) begin
                    next_r.state = DST_ERR1_RCV;
                end
            end
            DST_ERR1_RCV: begin
                if (is_invalid) begin
                    next_r.state = DST_ERR2;
                end else if (is_good) begin
                    next_r.state = DST_LOCKED;
                end
            end
            DST_ERR2: begin
                if (is_invalid) begin
                    next_r.state = DST_ERR3;
                end else if (is_good) begin
                    next_r.state = DST_ERR2_RCV;
                end
            end
            DST_ERR2_RCV: begin
                if (is_invalid) begin
                    next_r.state = DST_ERR3;
                end else if (is_good) begin
                    next_r.state = DST_ERR1;
                end
            end
            DST_ERR3, DST_ERR3_RCV: begin
                if (is_invalid) begin
                    next_r.sync_dropped_msg = 1'b1;
                    next_r.state = DST_HUNT;
                    next_r.hunting = 1'b1;
                    next_r.find_dword = 1'b1;
                end else if (is_good) begin
                    next_r.state = (r.state == DST_ERR3) ?
                        DST_ERR3_RCV : DST_ERR2;
                end
            end
            default: begin
                next_r.state = DST_HUNT;
            end
        endcase

        if (DWORD_VALID &&
            (r.state != DST_HUNT && r.state != DST_ONE_GOOD) &&
            !(r.state == DST_TWO_GOOD && !is_prim) &&
            next_r.state != DST_HUNT) begin
            next_r.fwd_valid = 1'b1;
            next_r.fwd_data = {DWORD_IN.ch0, DWORD_IN.ch1,
                               DWORD_IN.ch2, DWORD_IN.ch3};
            next_r.fwd_k = DWORD_IN.is_k;
        end

        if (SYNC_RESET || STOP_REQ || DISABLE_REQ || MGMT_RESET) begin
            next_r.state = DST_HUNT;
            next_r.hunting = 1'b0;
            next_r.timer_run = 1'b0;
            next_r.timeout = 1'b0;
            next_r.fwd_valid = 1'b0;
            next_r.find_dword = 1'b0;
            next_r.sync_dropped_msg = 1'b0;
        end
        next_r.locked = (next_r.state != DST_HUNT &&
                         next_r.state != DST_ONE_GOOD &&
                         next_r.state != DST_TWO_GOOD);

        // spin-up waits for grant after SAS out-of-band
        if (OOB_SAS_SEEN) begin
            next_sas_seen = 1'b1;
        end
        if (HOLD_ENABLE && !spin_held && !spin_allow) begin
            next_spin_held = 1'b1;
        end else if (HOLD_RELEASE) begin
            next_spin_held = 1'b0;
        end
        next_spin_allow = !next_spin_held &&
            (!(next_sas_seen) || SPINUP_GRANT || spin_allow);
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '{state: DST_HUNT, timer: '0, fwd_data: '0,
                   fwd_k: '0, default: 1'b0};
            spin_allow <= 1'b0;
            spin_held <= 1'b0;
            sas_seen <= 1'b0;
        end else begin
            r <= next_r;
            spin_allow <= next_spin_allow;
            spin_held <= next_spin_held;
            sas_seen <= next_sas_seen;
        end
    end

    assign FIND_DWORD = r.find_dword;
    assign SYNC_DROPPED = r.sync_dropped_msg;
    assign RESYNC_TIMEOUT = r.timeout;
    assign SYNC_LOCKED = r.locked;
    assign FWD_VALID = r.fwd_valid;
    assign FWD_DATA = r.fwd_data;
    assign FWD_K = r.fwd_k;
    assign SPINUP_ALLOW = spin_allow;
    assign SPINUP_HELD = spin_held;
endmodule

// ---- dv/dst_dword_src.sv ----
// Stand-in for the receiver that feeds aligned dwords.
`timescale 1ns/100ps
module dst_dword_src
    import dst_pkg::*;
(
    input wire logic [1:0] kind,
    input wire logic [31:0] rnd,
    output dst_dword_s dw
);
    always_comb begin
        dw = {rnd, 5'h00};
        case (kind)
            2'h1: {dw.ch0, dw.is_k} = {DST_K28_5, 4'h8};
            2'h2: {dw.ch0, dw.is_k} = {DST_K28_3, 4'h8};
            2'h3: begin
                // Low bits 11 keep a bad lead away from both legal codes.
                dw.ch0[1:0] = 2'h3;
                dw.is_k = rnd[1] ? (rnd[0] ? 4'h8 : 4'h9) : 4'h0;
                dw.code_err = !rnd[1];
            end
            default: ;
        endcase
    end
endmodule

// ---- dv/dst_sync_assertions.sv ----
// Port checker for the dword sync tracker.
`timescale 1ns/100ps
module dst_sync_chk
    import dst_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic STOP_REQ,
    input wire logic DISABLE_REQ,
    input wire logic MGMT_RESET,
    input wire logic SYNC_RESET,
    input wire logic DWORD_VALID,
    input wire dst_dword_s DWORD_IN,
    input wire logic FIND_DWORD,
    input wire logic SYNC_DROPPED,
    input wire logic SYNC_LOCKED,
    input wire logic FWD_VALID,
    input wire logic [31:0] FWD_DATA
);
    logic frc, bad, pv, bv;
    logic [31:0] word;
    assign frc = STOP_REQ | DISABLE_REQ | MGMT_RESET | SYNC_RESET;
    assign word = DWORD_IN[36:5];
    // A code error, a control code past the lead or a wrong lead code.
    assign bad = DWORD_IN.code_err || DWORD_IN.is_k[2:0] != 3'h0
        || DWORD_IN.is_k[3] && DWORD_IN.ch0 != DST_K28_5
        && DWORD_IN.ch0 != DST_K28_3;
    assign pv = DWORD_VALID && DWORD_IN.is_k[3] && !bad;
    assign bv = DWORD_VALID && bad;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    a_drop_one_shot: assert property (SYNC_DROPPED |=> !SYNC_DROPPED)
        else $error("sync drop pulse too long");
    a_drop_unlocks: assert property (
        SYNC_DROPPED |-> !SYNC_LOCKED && FIND_DWORD)
        else $error("drop without unlock and new hunt");
    a_drop_cause: assert property (SYNC_DROPPED |-> $past(bv))
        else $error("drop without an invalid dword");
    a_fwd_locked: assert property (FWD_VALID |-> SYNC_LOCKED)
        else $error("dword forwarded while unlocked");
    a_fwd_order: assert property (
        FWD_VALID |-> $past(DWORD_VALID) && FWD_DATA == $past(word))
        else $error("forwarded dword differs");
    a_lock_prim: assert property (
        $rose(SYNC_LOCKED) |-> $past(pv) && FWD_VALID)
        else $error("lock without forwarded primitive");
    a_valid_keeps: assert property (
        SYNC_LOCKED && DWORD_VALID && !bad && !frc |=> SYNC_LOCKED)
        else $error("valid dword lost lock");
    a_four_drop: assert property (
        (SYNC_LOCKED && bv && !frc)[*4] |=> SYNC_DROPPED)
        else $error("four invalid dwords kept lock");
    a_force_hunt: assert property (frc |=> !SYNC_LOCKED && !FWD_VALID)
        else $error("force did not return to hunt");
endmodule
bind dst_dword_sync_fsm dst_sync_chk u_chk (.CORE_CLK, .RESET_N, .STOP_REQ,
    .DISABLE_REQ, .MGMT_RESET, .SYNC_RESET, .DWORD_VALID, .DWORD_IN,
    .FIND_DWORD, .SYNC_DROPPED, .SYNC_LOCKED, .FWD_VALID, .FWD_DATA);

// ---- dv/tb_top.sv ----
// Self-checking bench for the dword sync tracker.
`timescale 1ns/100ps
module tb_top;
    import dst_pkg::*;
    localparam int RC = 1000;
    logic clk = 1'b0, rst_n = 1'b0, st = 1'b0, oob = 1'b1, gnt = 1'b0;
    logic dv = 1'b0, find, drop, tmo, lck, fv, alw, held;
    logic hen = 1'b0, hrel = 1'b0;
    logic e_find, e_drop, e_fv, bad, e_tmo, tout;
    logic [3:0] frc = 4'h0, fk, e_fk;
    logic [1:0] kind = 2'h0;
    logic [31:0] rnd = 32'h2BB461E8, fd, e_fd;
    dst_dword_s dw;
    int err_total = 0, compares = 0, cyc = 0, s = 0, tmr = 0;
    bit hunt = 0, tarm = 0;
    int nx_good[10] = '{0, 0, 0, 3, 5, 3, 7, 4, 9, 6};
    int nx_bad[10] = '{0, 0, 0, 4, 6, 6, 8, 8, 0, 0};
    logic [1:0] lad[14] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h3, 2'h2, 2'h0,
        2'h3, 2'h3, 2'h1, 2'h0, 2'h3, 2'h1, 2'h3};
    dst_dword_src u_src (.kind(kind), .rnd(rnd), .dw(dw));
    dst_dword_sync_fsm #(.RESYNC_CYCLES(RC)) u_dut (
        .CORE_CLK(clk), .RESET_N(rst_n), .START_REQ(st),
        .STOP_REQ(frc[0]), .DISABLE_REQ(frc[1]), .MGMT_RESET(frc[2]),
        .SYNC_RESET(frc[3]), .OOB_SAS_SEEN(oob), .SPINUP_GRANT(gnt),
        .HOLD_ENABLE(hen), .HOLD_RELEASE(hrel), .DWORD_VALID(dv),
        .DWORD_IN(dw), .FIND_DWORD(find), .SYNC_DROPPED(drop),
        .RESYNC_TIMEOUT(tmo), .SYNC_LOCKED(lck), .FWD_VALID(fv),
        .FWD_DATA(fd), .FWD_K(fk), .SPINUP_ALLOW(alw), .SPINUP_HELD(held));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic send(input logic [1:0] k, input int n);
        repeat (n) begin
            @(posedge clk);
            dv <= 1'b1;
            kind <= k;
        end
        @(posedge clk);
        dv <= 1'b0;
    endtask
    task automatic pulse_in(input logic [4:0] v);
        @(posedge clk);
        {frc, st} <= v;
        @(posedge clk);
        {frc, st} <= 5'h00;
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    // Reference model: predicts what each edge should show half a cycle on.
    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            err_total++;
            end_sim();
        end
        rnd <= xs(rnd);
        {e_find, e_drop} = 2'h0;
        e_fd = {dw.ch0, dw.ch1, dw.ch2, dw.ch3};
        e_fk = dw.is_k;
        bad = kind == 2'h3;
        // Timeout flag as the design held it before this edge.
        tout = tarm && tmr == 0;
        if (tarm && tmr > 0) tmr--;
        if (!rst_n || frc != 4'h0) begin
            s = 0;
            hunt = 0;
            tarm = 0;
        end else begin
            if (st && s == 0) begin
                hunt = 1;
                tarm = 1;
                tmr = RC;
                e_find = 1'b1;
            end
            if (s > 0 && s < 3 && (tout || dv && bad)) begin
                s = 0;
                e_find = 1'b1;
            end else if (dv && s < 3) begin
                if (kind != 2'h0 && !bad && (s > 0 || hunt && !st)) s++;
                if (s == 3) tarm = 0;
            end else if (dv) begin
                e_drop = bad && s >= 8;
                e_find = e_drop;
                s = bad ? nx_bad[s] : nx_good[s];
            end
        end
        e_tmo = tarm && tmr == 0;
        e_fv = dv && s >= 3 && frc == 4'h0;
    end
    always @(negedge clk) begin
        if (rst_n && cyc > 10) begin
            cmp(lck, s >= 3);
            cmp(fv, e_fv);
            cmp(drop, e_drop);
            cmp(find, e_find);
            cmp(tmo, e_tmo);
            if (e_fv) cmp(fd, e_fd);
            if (e_fv) cmp(fk, e_fk);
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        cmp(alw, 1'b0);
        @(posedge clk);
        hen <= 1'b1;
        repeat (2) @(negedge clk);
        cmp(held, 1'b1);
        @(posedge clk);
        gnt <= 1'b1;
        repeat (3) @(negedge clk);
        cmp(alw, 1'b0);
        @(posedge clk);
        {hen, hrel} <= 2'h1;
        @(posedge clk);
        hrel <= 1'b0;
        repeat (2) @(negedge clk);
        cmp(alw, 1'b1);
        cmp(held, 1'b0);
        send(2'h1, 3);
        $display("test spin-up and idle hunt done");
        // The climb stalls so the resync timer runs out partway up.
        pulse_in(5'h01);
        send(2'h1, 1);
        repeat (RC - 10) @(negedge clk);
        cmp(tmo, 1'b0);
        repeat (20) @(negedge clk);
        cmp(tmo, 1'b1);
        pulse_in(5'h01);
        send(2'h1, 1);
        send(2'h0, 1);
        send(2'h3, 1);
        send(2'h2, 3);
        $display("test timeout and climb done");
        foreach (lad[i]) send(lad[i], 1);
        send(2'h1, 3);
        send(2'h3, 4);
        $display("test error ladder done");
        for (int i = 0; i < 4; i++) begin
            pulse_in(5'h01);
            send(2'h1, 3);
            pulse_in(5'h02 << i);
            send(2'h1, 3);
        end
        $display("test forced hunt done");
        pulse_in(5'h01);
        send(2'h1, 3);
        repeat (300) begin
            @(posedge clk);
            dv <= rnd[7];
            kind <= rnd[5:4];
        end
        @(posedge clk);
        dv <= 1'b0;
        repeat (3) @(posedge clk);
        $display("test random stream done");
        end_sim();
    end
endmodule
